//--- common/mqf_map.svh
// constant map of the multi-queue flag block: register offsets, field
// positions, reset values and switch timing.
// assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
`ifndef MQF_MAP_SVH
`define MQF_MAP_SVH

// ==========================================
// register byte offsets
`define MQF_OFS_CONFIG 8'h00
`define MQF_OFS_STATUS 8'h04
`define MQF_OFS_FULLS 8'h08
`define MQF_OFS_EMPTIES 8'h0C

// ==========================================
// config fields
`define MQF_CFG_NQ_LSB 0
`define MQF_CFG_NQ_MSB 7
`define MQF_CFG_IDW_LSB 8
`define MQF_CFG_IDW_MSB 9
`define MQF_CFG_WORD_LSB 10
`define MQF_CFG_WORD_MSB 13
`define MQF_CFG_RESET 32'h0000_0080

// ==========================================
// status fields
`define MQF_ST_MODE 0
`define MQF_ST_FULLN 1
`define MQF_ST_FULLOE 2
`define MQF_ST_EMPTYN 3
`define MQF_ST_EMPTYOE 4
`define MQF_ST_AFN 5
`define MQF_ST_WRQ_LSB 8
`define MQF_ST_RDQ_LSB 16
`define MQF_ST_BUS_LSB 24

// ==========================================
// timing and bus answers
`define MQF_SWITCH_LAT 2'h3
`define MQF_SWITCH_APPLY 2'h1
`define MQF_BUS_LINES 8
`define MQF_RESP_OKAY 2'h0
`define MQF_RESP_SLVERR 2'h2

`endif

//--- common/mqf_pkg.sv
// types of the multi-queue flag block.
// assumes mqf_map.svh for every number.
package mqf_pkg;

  // ==========================================
  // flag bus sharing scheme, latched at the first edge after master reset
  typedef enum logic {
    MQF_DIRECT,
    MQF_POLLED
  } mqf_flag_mode_t;

  // ==========================================
  // software configuration carried as one word
  typedef struct packed {
    logic [17:0] spare;
    logic [3:0] statusWord;
    logic [1:0] idWidth;
    logic [7:0] numQueues;
  } mqf_cfg_t;

  // ==========================================
  // pending queue selection on one port
  typedef struct packed {
    logic own;
    logic [6:0] queue;
  } mqf_sel_t;

endpackage

//--- rtl/mqf_flags.sv
// status flag logic of a multi-queue flow-control memory: active queue
// full and empty flags with expansion float control, an almost-full flag, and
// the shared eight-line almost-full status bus.
// assumes write and read ports share ref_clk and inputs are synchronous.
//
// Overview of operation
// - eight-line bus shows eight queues at once
// - nine or more queues share bus, mode strapped
// - eight or fewer queues: one fixed line each
// - full kept per queue, active one driven
// - full flag shows new queue third edge later
// - first write to new queue at fourth edge
// - full flag changes only on clock edges
// - reads update full status of idle queues
// - full flag floats when no own queue selected
// - write address top bits match device code
// - same-device switches keep driving full flag
// - empty kept per queue, one flag output
// - empty flag changes on output register load
// - empty flag floats when no own queue selected
// - read address top bits match device code
// - same-device switches keep driving empty flag
// - low mode strap selects direct bus scheme
// - empty flag updated third switch cycle
`timescale 1ns/1ps
`include "mqf_map.svh"
module mqf_flags #(
  parameter int NQ = 128,
  parameter int QAW = 8,
  parameter int QIW = 7,
  parameter int DEPTH = 512,
  parameter int AF_GAP = 8
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic flag_sharing_select,
  input wire logic device_code_bit0,
  input wire logic device_code_bit1,
  input wire logic device_code_bit2,
  input wire logic [QAW-1:0] write_queue_addr,
  input wire logic write_addr_enable,
  input wire logic wordWrite,
  input wire logic [QAW-1:0] read_queue_addr,
  input wire logic read_addr_enable,
  input wire logic wordRead,
  output logic active_queue_full_n,
  output logic activeQueueFullOe,
  output logic active_almost_full_n,
  output logic active_queue_empty_n,
  output logic activeQueueEmptyOe,
  output logic [`MQF_BUS_LINES-1:0] almost_full_status_bus,
  output logic [3:0] almostFullWord
);

  mqf_pkg::mqf_cfg_t cfg;
  mqf_pkg::mqf_flag_mode_t flagMode;
  mqf_pkg::mqf_sel_t wrSel;
  mqf_pkg::mqf_sel_t rdSel;
  logic modeTaken;
  logic [2:0] deviceCode;
  logic [NQ-1:0] fullVec;
  logic [NQ-1:0] emptyVec;
  logic [NQ-1:0] almostFullVec;
  logic [1:0] wrCount;
  logic [1:0] rdCount;
  logic wrApply;
  logic rdApply;
  logic [QIW-1:0] activeWr;
  logic [QIW-1:0] activeRd;
  logic wrOwn;
  logic rdOwn;
  logic [QIW-1:0] wrShowQ;
  logic [QIW-1:0] rdShowQ;
  logic [5:0] wordCount;
  logic [3:0] pollWord;
  logic [3:0] busWord;
  logic awHeld;
  logic wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic doWrite;
  logic [31:0] readWord;
  logic [1:0] readResp;

  assign deviceCode = {device_code_bit2, device_code_bit1, device_code_bit0};

  // ==========================================
  // device code compare and local queue index
  function automatic logic codeMatch(input logic [QAW-1:0] a,
                                     input logic [1:0] w,
                                     input logic [2:0] code);
    case (w)
      2'h0: codeMatch = 1'b1;
      2'h1: codeMatch = (a[QAW-1] == code[0]);
      2'h2: codeMatch = (a[QAW-1 -: 2] == code[1:0]);
      default: codeMatch = (a[QAW-1 -: 3] == code);
    endcase
  endfunction

  function automatic logic [QIW-1:0] localQueue(input logic [QAW-1:0] a,
                                                input logic [1:0] w);
    logic [QAW-1:0] keep;
    keep = {QAW{1'b1}} >> w;
    localQueue = QIW'(a & keep);
  endfunction

  // ==========================================
  // flag mode strap
  // the strap must be steady across reset; it is taken at the first
  // edge after release and never again until the next reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      modeTaken <= 1'b0;
      flagMode <= mqf_pkg::MQF_DIRECT;
    end else if (!modeTaken) begin
      modeTaken <= 1'b1;
      flagMode <= flag_sharing_select ? mqf_pkg::MQF_POLLED
                                      : mqf_pkg::MQF_DIRECT;
    end
  end

  // ==========================================
  // write port queue switch
  assign wrApply = (wrCount == `MQF_SWITCH_APPLY);
  assign wrShowQ = wrApply ? wrSel.queue : activeWr;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wrCount <= '0;
      wrSel <= '0;
    end else if (write_addr_enable) begin
      wrSel.own <= codeMatch(write_queue_addr, cfg.idWidth,
                             deviceCode);
      wrSel.queue <= localQueue(write_queue_addr, cfg.idWidth);
      wrCount <= `MQF_SWITCH_LAT;
    end else if (wrCount != '0) begin
      wrCount <= wrCount - 2'h1;
    end
  end

  // the new queue takes over at the third edge; writes up to then still
  // land in the old queue, so the fourth edge is the first to the new one
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      activeWr <= '0;
      wrOwn <= 1'b0;
    end else if (wrApply) begin
      activeWr <= wrSel.queue;
      wrOwn <= wrSel.own;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      active_queue_full_n <= 1'b1;
      active_almost_full_n <= 1'b1;
      activeQueueFullOe <= 1'b0;
    end else begin
      active_queue_full_n <= !fullVec[wrShowQ];
      active_almost_full_n <= !almostFullVec[wrShowQ];
      activeQueueFullOe <= wrApply ? wrSel.own : wrOwn;
    end
  end

  // ==========================================
  // read port queue switch
  assign rdApply = (rdCount == `MQF_SWITCH_APPLY);
  assign rdShowQ = rdApply ? rdSel.queue : activeRd;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdCount <= '0;
      rdSel <= '0;
    end else if (read_addr_enable) begin
      rdSel.own <= codeMatch(read_queue_addr, cfg.idWidth,
                             deviceCode);
      rdSel.queue <= localQueue(read_queue_addr, cfg.idWidth);
      rdCount <= `MQF_SWITCH_LAT;
    end else if (rdCount != '0) begin
      rdCount <= rdCount - 2'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      activeRd <= '0;
      rdOwn <= 1'b0;
    end else if (rdApply) begin
      activeRd <= rdSel.queue;
      rdOwn <= rdSel.own;
    end
  end

  // the flag register loads on every edge from the shown read queue
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      active_queue_empty_n <= 1'b0;
      activeQueueEmptyOe <= 1'b0;
    end else begin
      active_queue_empty_n <= !emptyVec[rdShowQ];
      activeQueueEmptyOe <= rdApply ? rdSel.own : rdOwn;
    end
  end

  // ==========================================
  // per-queue status
  mqf_queue_status #(
    .NQ(NQ),
    .QIW(QIW),
    .DEPTH(DEPTH),
    .AF_GAP(AF_GAP)
  ) u_status (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .push(wordWrite && wrOwn),
    .pushQueue(activeWr),
    .pop(wordRead && rdOwn),
    .popQueue(activeRd),
    .fullVec(fullVec),
    .emptyVec(emptyVec),
    .almostFullVec(almostFullVec)
  );

  // ==========================================
  // almost-full status bus
  assign wordCount = 6'((9'(cfg.numQueues) + 9'h7) >> 3);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pollWord <= '0;
    end else if ({2'h0, pollWord} + 6'h01 >= wordCount) begin
      pollWord <= '0;
    end else begin
      pollWord <= pollWord + 4'h1;
    end
  end

  always_comb begin
    if (cfg.numQueues <= 8'(`MQF_BUS_LINES)) begin
      busWord = '0;
    end else if (flagMode == mqf_pkg::MQF_POLLED) begin
      busWord = pollWord;
    end else begin
      busWord = cfg.statusWord;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      almost_full_status_bus <= '1;
      almostFullWord <= '0;
    end else begin
      almost_full_status_bus <=
        ~almostFullVec[busWord * `MQF_BUS_LINES +: `MQF_BUS_LINES];
      almostFullWord <= busWord;
    end
  end

  // ==========================================
  // axi4-lite write channel
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= '0;
      wStrb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MQF_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr == `MQF_OFS_CONFIG) ? `MQF_RESP_OKAY
                                                    : `MQF_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg <= `MQF_CFG_RESET;
    end else if (doWrite && awAddr == `MQF_OFS_CONFIG) begin
      for (int b = 0; b < 4; b++) begin
        if (wStrb[b]) begin
          cfg[b*8 +: 8] <= wData[b*8 +: 8];
        end
      end
    end
  end

  // ==========================================
  // axi4-lite read channel
  always_comb begin
    readWord = '0;
    readResp = `MQF_RESP_OKAY;
    case (s_axi_araddr)
      `MQF_OFS_CONFIG: begin
        readWord = cfg;
      end
      `MQF_OFS_STATUS: begin
        readWord[`MQF_ST_MODE] = (flagMode == mqf_pkg::MQF_POLLED);
        readWord[`MQF_ST_FULLN] = active_queue_full_n;
        readWord[`MQF_ST_FULLOE] = activeQueueFullOe;
        readWord[`MQF_ST_EMPTYN] = active_queue_empty_n;
        readWord[`MQF_ST_EMPTYOE] = activeQueueEmptyOe;
        readWord[`MQF_ST_AFN] = active_almost_full_n;
        readWord[`MQF_ST_WRQ_LSB +: QIW] = activeWr;
        readWord[`MQF_ST_RDQ_LSB +: QIW] = activeRd;
        readWord[`MQF_ST_BUS_LSB +: `MQF_BUS_LINES] = almost_full_status_bus;
      end
      `MQF_OFS_FULLS: begin
        readWord = 32'(fullVec);
      end
      `MQF_OFS_EMPTIES: begin
        readWord = 32'(emptyVec);
      end
      default: begin
        readResp = `MQF_RESP_SLVERR;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `MQF_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readWord;
      s_axi_rresp <= readResp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- rtl/mqf_queue_status.sv
// per-queue fill tracking: full, empty and almost-full status of
// every queue, updated by writes and reads on either port.
// assumes pushes and pops are already qualified to this device.
`timescale 1ns/1ps
module mqf_queue_status #(
  parameter int NQ = 128,
  parameter int QIW = 7,
  parameter int DEPTH = 512,
  parameter int AF_GAP = 8
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic push,
  input wire logic [QIW-1:0] pushQueue,
  input wire logic pop,
  input wire logic [QIW-1:0] popQueue,
  output logic [NQ-1:0] fullVec,
  output logic [NQ-1:0] emptyVec,
  output logic [NQ-1:0] almostFullVec
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_AT = CW'(DEPTH);
  localparam logic [CW-1:0] AF_AT = CW'(DEPTH - AF_GAP);

  // ==========================================
  // one counter per queue
  genvar i;
  generate
    for (i = 0; i < NQ; i++) begin : g_queue
      logic [CW-1:0] count;
      logic inc;
      logic dec;
      assign inc = push && (pushQueue == QIW'(i)) && !fullVec[i];
      assign dec = pop && (popQueue == QIW'(i)) && !emptyVec[i];
      // reads change status of any queue, active or not
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          count <= '0;
        end else if (inc && !dec) begin
          count <= count + CW'(1);
        end else if (dec && !inc) begin
          count <= count - CW'(1);
        end
      end
      // status kept for every queue
      assign fullVec[i] = (count == FULL_AT);
      assign emptyVec[i] = (count == '0);
      assign almostFullVec[i] = (count >= AF_AT);
    end
  endgenerate

endmodule

//--- verification/mqf_ctl_model.sv
// controller model driving the queue write and read ports.
// assumes the bench calls its tasks; one device, so its flags are
// the shared ones.
`timescale 1ns/1ps
module mqf_ctl_model (
  input wire logic ref_clk,
  output logic [7:0] write_queue_addr,
  output logic write_addr_enable,
  output logic wordWrite,
  output logic [7:0] read_queue_addr,
  output logic read_addr_enable,
  output logic wordRead
);
  // ==========================================
  // idle levels
  initial begin
    write_queue_addr = 8'h00;
    read_queue_addr = 8'h00;
    {write_addr_enable, wordWrite, read_addr_enable, wordRead} = '0;
  end
  // ==========================================
  // queue switches, waiting out the switch cycles
  task automatic selW(input logic [7:0] q);
    @(posedge ref_clk);
    write_queue_addr <= q;
    write_addr_enable <= 1'b1;
    @(posedge ref_clk);
    write_queue_addr <= ~q;
    write_addr_enable <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic selR(input logic [7:0] q);
    @(posedge ref_clk);
    read_queue_addr <= q;
    read_addr_enable <= 1'b1;
    @(posedge ref_clk);
    read_queue_addr <= ~q;
    read_addr_enable <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic push(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      wordWrite <= 1'b1;
    end
    @(posedge ref_clk);
    wordWrite <= 1'b0;
  endtask
  task automatic pop(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      wordRead <= 1'b1;
    end
    @(posedge ref_clk);
    wordRead <= 1'b0;
  endtask
endmodule

//--- verification/mqf_flags_asserts.sv
// port checker of the multi-queue flag block.
// assumes it is bound into mqf_flags, one clock domain.
`timescale 1ns/1ps
module mqf_flags_asserts (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic write_addr_enable,
  input wire logic wordWrite,
  input wire logic read_addr_enable,
  input wire logic wordRead,
  input wire logic active_queue_full_n,
  input wire logic activeQueueFullOe,
  input wire logic active_queue_empty_n,
  input wire logic activeQueueEmptyOe,
  input wire logic [7:0] almost_full_status_bus
);
  // ==========================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  sequence wTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_reset_idle: assert property (
    $rose(rstn) |-> active_queue_full_n && !active_queue_empty_n
    && !activeQueueFullOe && !activeQueueEmptyOe
    && almost_full_status_bus == 8'hFF)
    else $error("flags not idle after reset");
  a_full_cause: assert property (
    $changed(active_queue_full_n) |-> $past(write_addr_enable, 4)
    || $past(wordWrite, 2) || $past(wordRead, 2))
    else $error("full flag moved without cause");
  a_empty_cause: assert property (
    $changed(active_queue_empty_n) |-> $past(read_addr_enable, 4)
    || $past(wordWrite, 2) || $past(wordRead, 2))
    else $error("empty flag moved without cause");
  a_full_oe_cause: assert property (
    $changed(activeQueueFullOe) |-> $past(write_addr_enable, 4))
    else $error("full enable moved off switch timing");
  a_empty_oe_cause: assert property (
    $changed(activeQueueEmptyOe) |-> $past(read_addr_enable, 4))
    else $error("empty enable moved off switch timing");
  a_write_resp: assert property (wTaken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_resp: assert property (rTaken |=> s_axi_rvalid)
    else $error("read response late");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_refuse: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_bvalid_clear: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not cleared");
endmodule

bind mqf_flags mqf_flags_asserts chk (.*);

//--- verification/tb_multiqueue_full_empty_flags.sv
// self-checking bench of the multi-queue flag block.
// assumes mqf_ctl_model on the queue ports and the bound checker.
`timescale 1ns/1ps
`include "mqf_map.svh"
module tb_multiqueue_full_empty_flags;
  int fail_count = 0;
  int cmp_count = 0;
  logic ref_clk, rstn, flag_sharing_select;
  logic device_code_bit0, device_code_bit1, device_code_bit2;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [7:0] write_queue_addr, read_queue_addr, almost_full_status_bus;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, almostFullWord, w;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, active_almost_full_n;
  logic write_addr_enable, wordWrite, read_addr_enable, wordRead;
  logic active_queue_full_n, activeQueueFullOe;
  logic active_queue_empty_n, activeQueueEmptyOe;

  mqf_flags #(.DEPTH(4), .AF_GAP(1)) dut (.*);
  mqf_ctl_model ctl (.*);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ==========================================
  // shared tasks
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask
  function automatic logic [31:0] flags();
    return {28'h000_0000, active_queue_full_n, activeQueueFullOe,
      active_queue_empty_n, activeQueueEmptyOe};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic doReset(input logic mode);
    @(posedge ref_clk);
    rstn <= 1'b0;
    flag_sharing_select <= mode;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    tick(2);
  endtask
  task automatic axWrite(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r, input logic [3:0] s = 4'hF);
    int n;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) fail_count++;
    if (n == 50) summarize();
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(r));
  endtask
  task automatic axRead(input logic [7:0] a, input logic [1:0] r,
      output logic [31:0] d);
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) fail_count++;
    if (n == 50) summarize();
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rresp", 32'(s_axi_rresp), 32'(r));
  endtask
  // ==========================================
  // scenarios
  task automatic testReset();
    doReset(1'b1);
    chk("flags", flags(), 32'h0000_0008);
    chk("bus", 32'(almost_full_status_bus), 32'h0000_00FF);
    axRead(`MQF_OFS_CONFIG, `MQF_RESP_OKAY, rd);
    chk("config", rd, `MQF_CFG_RESET);
    axRead(8'h10, `MQF_RESP_SLVERR, rd);
    chk("unmapped", rd, 32'h0000_0000);
    axWrite(`MQF_OFS_STATUS, 32'h0000_0000, `MQF_RESP_SLVERR);
    axRead(`MQF_OFS_STATUS, `MQF_RESP_OKAY, rd);
    chk("mode", 32'(rd[`MQF_ST_MODE]), 32'h0000_0001);
    $display("reset test done");
  endtask
  task automatic testFull();
    ctl.selW(8'h01);
    chk("flags", flags(), 32'h0000_000C);
    ctl.push(4);
    tick(2);
    chk("flags", flags(), 32'h0000_0004);
    axRead(`MQF_OFS_FULLS, `MQF_RESP_OKAY, rd);
    chk("fulls", rd, 32'h0000_0002);
    ctl.selW(8'h02);
    chk("flags", flags(), 32'h0000_000C);
    ctl.selR(8'h01);
    chk("flags", flags(), 32'h0000_000F);
    ctl.pop(1);
    tick(2);
    axRead(`MQF_OFS_FULLS, `MQF_RESP_OKAY, rd);
    chk("fulls", rd, 32'h0000_0000);
    ctl.selR(8'h03);
    chk("flags", flags(), 32'h0000_000D);
    axRead(`MQF_OFS_EMPTIES, `MQF_RESP_OKAY, rd);
    chk("empties", rd, 32'hFFFF_FFFD);
    $display("full test done");
  endtask
  task automatic testExpand();
    axWrite(`MQF_OFS_CONFIG, 32'h0000_0180, `MQF_RESP_OKAY);
    ctl.selW(8'h81);
    ctl.selR(8'h81);
    chk("oe", flags() & 32'h0000_0005, 32'h0000_0000);
    ctl.selW(8'h01);
    ctl.selR(8'h02);
    chk("flags", flags(), 32'h0000_000D);
    @(posedge ref_clk);
    device_code_bit0 <= 1'b1;
    ctl.selW(8'h81);
    chk("oe", flags() & 32'h0000_0004, 32'h0000_0004);
    axWrite(`MQF_OFS_CONFIG, 32'h0000_0380, `MQF_RESP_OKAY);
    device_code_bit1 <= 1'b1;
    device_code_bit2 <= 1'b1;
    ctl.selW(8'hE5);
    ctl.selR(8'hC5);
    chk("oe", flags() & 32'h0000_0005, 32'h0000_0004);
    $display("expansion test done");
  endtask
  task automatic testMode();
    axWrite(`MQF_OFS_CONFIG, `MQF_CFG_RESET, `MQF_RESP_OKAY);
    tick(1);
    w = almostFullWord + 4'h1;
    tick(1);
    chk("word", 32'(almostFullWord), 32'(w));
    axWrite(`MQF_OFS_CONFIG, 32'h0000_0008, `MQF_RESP_OKAY);
    ctl.selW(8'h00);
    ctl.push(3);
    tick(3);
    chk("word", 32'(almostFullWord), 32'h0000_0000);
    chk("bus", 32'(almost_full_status_bus), 32'h0000_00FC);
    chk("afull", 32'(active_almost_full_n), 32'h0000_0000);
    doReset(1'b0);
    @(posedge ref_clk);
    flag_sharing_select <= 1'b1;
    axRead(`MQF_OFS_STATUS, `MQF_RESP_OKAY, rd);
    chk("mode", 32'(rd[`MQF_ST_MODE]), 32'h0000_0000);
    axWrite(`MQF_OFS_CONFIG, 32'h0000_0880, `MQF_RESP_OKAY);
    tick(2);
    chk("word", 32'(almostFullWord), 32'h0000_0002);
    axWrite(`MQF_OFS_CONFIG, 32'hFFFF_0C00, `MQF_RESP_OKAY, 4'h2);
    axRead(`MQF_OFS_CONFIG, `MQF_RESP_OKAY, rd);
    chk("config", rd, 32'h0000_0C80);
    chk("word", 32'(almostFullWord), 32'h0000_0003);
    $display("mode test done");
  endtask

  initial begin
    rstn = 1'b0;
    flag_sharing_select = 1'b1;
    {device_code_bit0, device_code_bit1, device_code_bit2} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    testReset();
    testFull();
    testExpand();
    testMode();
    summarize();
  end
endmodule
